// File: cbo_alarm_regs.sv
// Control byte decode, conversion timing and over-temperature alarm
//
// Function
// - A completed eight-bit serial write is the only way to load either register, and it goes to exactly one.
// - A byte with its upper five bits zero loads its low three bits into the channel select register only.
// - A byte with any upper bit set loads all eight bits into the threshold register only.
// - The channel select is three bits: 000 temperature, 001 to 100 inputs one to four, 111 band gap.
// - A conversion started with code 111 selected connects the converter to the band gap reference.
// - After reset the channel select holds zero, selecting the temperature sensor.
// - At the end of each temperature conversion the top eight result bits are compared with the threshold.
// - When those eight bits are strictly greater than the threshold the alarm output goes low.
// - The alarm returns high at the end of a serial read or when a new temperature is not above threshold.
// - After reset the threshold register holds 153, an alarm above 50 degrees.
// - A conversion starts on the falling convert start edge; still low at the end means power down.
// - A temperature conversion takes 27 us and an input channel conversion 9 us.
// - The end of a serial read is the rising edge of the read-write select input.
`timescale 1ns/1ps
`include "cbo_defs.svh"

module cbo_alarm_regs #(
  parameter int TEMP_CONV_CYC = `CBO_TEMP_CONV_CYC,
  parameter int ADC_CONV_CYC  = `CBO_ADC_CONV_CYC
) (
  input  wire logic                          clk_sys,
  input  wire logic                          rst_n,
  input  wire logic                          sclk,
  input  wire logic                          sdata_in,
  input  wire logic                          rd_wr,
  input  wire logic                          convert_start_n,
  input  wire logic [`CBO_RESULT_BITS-1:0]   adc_result,
  output logic      [2:0]                    channel_select,
  output logic                               overtemp_alarm_n,
  output cbo_pkg::cbo_conv_t                 conv_status
);
  import cbo_pkg::*;

  localparam int CW = `CBO_CNT_W;

  // Refuse lengths the down counter cannot hold
  // Zero would wrap the loaded count to all ones, the longest conversion
  if (TEMP_CONV_CYC < 1 || TEMP_CONV_CYC >= (1 << CW) ||
      ADC_CONV_CYC < 1 || ADC_CONV_CYC >= (1 << CW)) begin : g_bad_counts
    $error("conversion counts do not fit the counter");
  end

  // Pin synchronisers; stage one feeds stage two only
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic       sclk_d_reg;
  logic       rw_d_reg;
  logic       conv_d_reg;
  logic       sclk_s;
  logic       din_s;
  logic       rw_s;
  logic       conv_s;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg  <= 4'hd;
      sync2_reg  <= 4'hd;
      sclk_d_reg <= 1'b1;
      rw_d_reg   <= 1'b0;
      conv_d_reg <= 1'b1;
    end else begin
      sync1_reg  <= {sclk, sdata_in, rd_wr, convert_start_n};
      sync2_reg  <= sync1_reg;
      sclk_d_reg <= sync2_reg[3];
      rw_d_reg   <= sync2_reg[1];
      conv_d_reg <= sync2_reg[0];
    end
  end

  assign sclk_s = sync2_reg[3];
  assign din_s  = sync2_reg[2];
  assign rw_s   = sync2_reg[1];
  assign conv_s = sync2_reg[0];

  // Edge history resets to pin idle levels, so release makes no false edge
  logic sclk_rise;
  logic rw_edge;
  logic read_end;
  logic conv_fall;

  assign sclk_rise = sclk_s && !sclk_d_reg;
  assign rw_edge   = rw_s != rw_d_reg;
  assign read_end  = rw_s && !rw_d_reg;
  assign conv_fall = !conv_s && conv_d_reg;

  // Serial write receiver, MSB first; a read-write change restarts the byte
  // Count wraps to zero on the eighth bit, ready for the next byte
  logic [6:0]    shift_reg;
  logic [2:0]    bit_cnt_reg;
  logic          byte_done_reg;
  cbo_ctl_byte_t ctl_byte_reg;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg     <= 7'h00;
      bit_cnt_reg   <= 3'h0;
      byte_done_reg <= 1'b0;
      ctl_byte_reg  <= 8'h00;
    end else begin
      byte_done_reg <= 1'b0;
      if (rw_edge) begin
        bit_cnt_reg <= 3'h0;
      end else if (sclk_rise && !rw_s) begin
        shift_reg   <= {shift_reg[5:0], din_s};
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        if (bit_cnt_reg == 3'h7) begin
          byte_done_reg <= 1'b1;
          ctl_byte_reg  <= {shift_reg, din_s};
        end
      end
    end
  end

  // Byte routing to one of two registers
  logic [7:0] threshold_reg;
  logic       upper_zero;

  assign upper_zero = ctl_byte_reg.upper == 5'h00;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      channel_select <= `CBO_SEL_RESET;
      threshold_reg  <= `CBO_THR_RESET;
    end else if (byte_done_reg) begin
      if (upper_zero) begin
        channel_select <= ctl_byte_reg.sel;
      end else begin
        threshold_reg <= ctl_byte_reg;
      end
    end
  end

  // Conversion sequencer; host keeps acquisition spacing, so no start guard here
  cbo_state_t      state_reg;
  logic [CW-1:0]   cnt_reg;
  logic [2:0]      chan_q_reg;
  logic            conv_end_reg;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg    <= CBO_ST_IDLE;
      cnt_reg      <= '0;
      chan_q_reg   <= `CBO_SEL_TEMP;
      conv_end_reg <= 1'b0;
      conv_status  <= '0;
    end else begin
      conv_end_reg <= 1'b0;
      case (state_reg)
        CBO_ST_IDLE: begin
          if (conv_fall) begin
            state_reg              <= CBO_ST_CONV;
            chan_q_reg             <= channel_select;
            cnt_reg                <= (channel_select == `CBO_SEL_TEMP) ?
                                      CW'(TEMP_CONV_CYC - 1) : CW'(ADC_CONV_CYC - 1);
            conv_status.busy       <= 1'b1;
            conv_status.hold       <= 1'b1;
            conv_status.power_down <= 1'b0;
            conv_status.bandgap    <= channel_select == `CBO_SEL_BANDGAP;
          end
        end
        CBO_ST_CONV: begin
          if (cnt_reg == '0) begin
            state_reg              <= CBO_ST_IDLE;
            conv_end_reg           <= 1'b1;
            conv_status.busy       <= 1'b0;
            conv_status.hold       <= 1'b0;
            conv_status.bandgap    <= 1'b0;
            conv_status.power_down <= !conv_s;
          end else begin
            cnt_reg <= cnt_reg - CW'(1);
          end
        end
        default: begin
          state_reg <= CBO_ST_IDLE;
        end
      endcase
    end
  end

  // Result is sampled one cycle after the sequencer ends, core output then settled
  logic       temp_end;
  logic [7:0] result_hi;
  logic       over;

  assign temp_end  = conv_end_reg && chan_q_reg == `CBO_SEL_TEMP;
  assign result_hi = adc_result[`CBO_RESULT_BITS-1 -: 8];
  assign over      = result_hi > threshold_reg;

  // New over-threshold result wins over a simultaneous read end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      overtemp_alarm_n <= 1'b1;
    end else if (temp_end && over) begin
      overtemp_alarm_n <= 1'b0;
    end else if (temp_end || read_end) begin
      overtemp_alarm_n <= 1'b1;
    end
  end

  // Helper for the duration check
  // One bit wider than the down counter, so a stuck busy still shows
  logic [CW:0] busy_len_reg;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      busy_len_reg <= '0;
    end else if (conv_status.busy) begin
      busy_len_reg <= busy_len_reg + (CW+1)'(1);
    end else begin
      busy_len_reg <= '0;
    end
  end

  sel_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    byte_done_reg && upper_zero |=>
      channel_select == $past(ctl_byte_reg.sel) && $stable(threshold_reg))
    else $error("channel select write wrong");

  thr_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    byte_done_reg && !upper_zero |=>
      threshold_reg == $past(ctl_byte_reg) && $stable(channel_select))
    else $error("threshold write wrong");

  no_stray_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !byte_done_reg |=> $stable(channel_select) && $stable(threshold_reg))
    else $error("register changed without a write");

  alarm_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    temp_end && over |=> !overtemp_alarm_n)
    else $error("alarm not raised");

  alarm_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (read_end && !temp_end) || (temp_end && !over) |=> overtemp_alarm_n)
    else $error("alarm not released");

  other_chan_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !temp_end && !read_end |=> $stable(overtemp_alarm_n))
    else $error("alarm moved without cause");

  conv_time_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $fell(conv_status.busy) |->
      busy_len_reg == ((chan_q_reg == `CBO_SEL_TEMP) ? TEMP_CONV_CYC : ADC_CONV_CYC))
    else $error("conversion length wrong");

  conv_start_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    conv_fall && state_reg == CBO_ST_IDLE |=>
      conv_status.busy && conv_status.hold && !conv_status.power_down)
    else $error("conversion did not start");

  bandgap_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(conv_status.busy) |->
      conv_status.bandgap == (chan_q_reg == `CBO_SEL_BANDGAP))
    else $error("band gap select wrong");

  power_down_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $fell(conv_status.busy) |-> conv_status.power_down == !$past(conv_s))
    else $error("power down decision wrong");

  // Serial and sequencer guards below see the synchronised pins only
  byte_len_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    byte_done_reg |-> $past(bit_cnt_reg) == 3'h7 && bit_cnt_reg == 3'h0)
    else $error("byte completed early");

  read_ignore_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sclk_rise && rw_s && !rw_edge |=> $stable(bit_cnt_reg) && !byte_done_reg)
    else $error("bit taken during a read");

  rw_restart_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rw_edge |=> bit_cnt_reg == 3'h0 && !byte_done_reg)
    else $error("partial byte survived a read-write change");

  conv_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_reg == CBO_ST_CONV && cnt_reg != '0 |=>
      state_reg == CBO_ST_CONV && conv_status.busy && $stable(chan_q_reg))
    else $error("conversion cut short or channel moved");

  state_onehot_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $onehot(state_reg))
    else $error("sequencer state not one-hot");

  bandgap_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !conv_status.busy |-> !conv_status.bandgap && !conv_status.hold)
    else $error("band gap or hold left on");

  conv_load_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(conv_status.busy) |->
      cnt_reg == ((chan_q_reg == `CBO_SEL_TEMP) ?
                  CW'(TEMP_CONV_CYC - 1) : CW'(ADC_CONV_CYC - 1)))
    else $error("conversion length not loaded");

  input_chan_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    conv_end_reg && chan_q_reg != `CBO_SEL_TEMP && !read_end |=>
      $stable(overtemp_alarm_n))
    else $error("input channel moved the alarm");

endmodule // cbo_alarm_regs

// File: cbo_defs.svh
// Field positions, reset values and timing counts for the control byte block
`ifndef CBO_DEFS_SVH
`define CBO_DEFS_SVH

`define CBO_BYTE_BITS     8
`define CBO_UPPER_MSB     7
`define CBO_UPPER_LSB     3
`define CBO_SEL_MSB       2
`define CBO_SEL_RESET     3'h0
`define CBO_THR_RESET     8'h99
`define CBO_SEL_TEMP      3'h0
`define CBO_SEL_BANDGAP   3'h7
`define CBO_RESULT_BITS   10
`define CBO_CLK_MHZ       100
`define CBO_TEMP_CONV_US  27
`define CBO_ADC_CONV_US   9
`define CBO_TEMP_CONV_CYC (`CBO_TEMP_CONV_US * `CBO_CLK_MHZ)
`define CBO_ADC_CONV_CYC  (`CBO_ADC_CONV_US * `CBO_CLK_MHZ)
`define CBO_CNT_W         12

`endif

// File: cbo_host_model.sv
// Host model driving the serial port and convert start pins
`timescale 1ns/1ps
module cbo_host_model (
  input  wire logic clk_sys,
  output logic      sclk,
  output logic      sdata_in,
  output logic      rd_wr,
  output logic      convert_start_n
);
  localparam int HALF = 8;  // 80 ns half period of the serial clock
  localparam int ACQ  = 40; // Generous gap, well over the acquisition need

  initial begin
    sclk            = 1'b1;
    sdata_in        = 1'b1;
    rd_wr           = 1'b0;
    convert_start_n = 1'b1;
  end

  task automatic idle(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  function automatic logic [7:0] alarm_code(input int deg);
    return 8'(deg + 103);
  endfunction

  // Sends the top n bits, MSB first; with rw high the device must ignore them
  task automatic write_bits(input logic [7:0] b, input int n, input logic rw);
    rd_wr = rw;
    for (int i = 7; i > 7 - n; i--) begin
      sclk     = ~sclk;
      sdata_in = b[i];
      idle(HALF);
      sclk = ~sclk;
      idle(HALF);
    end
    sdata_in = ~b[8 - n]; // Released line must not show a stale bit
    idle(HALF);
  endtask

  task automatic write_byte(input logic [7:0] b);
    write_bits(b, 8, 1'b0);
  endtask

  task automatic read_end();
    rd_wr = 1'b1;
    idle(HALF);
    rd_wr = 1'b0; // Rising edge above ends the read
    idle(HALF);
  endtask

  task automatic start();
    convert_start_n = 1'b1;
    idle(ACQ);
    convert_start_n = 1'b0;
  endtask

  task automatic release_start();
    convert_start_n = 1'b1;
  endtask
endmodule // cbo_host_model

// File: cbo_pkg.sv
// Types shared by the control byte and over-temperature alarm block
package cbo_pkg;

  typedef enum logic [1:0] {
    CBO_ST_IDLE = 2'b01,
    CBO_ST_CONV = 2'b10
  } cbo_state_t;

  typedef struct packed {
    logic       busy;
    logic       hold;
    logic       bandgap;
    logic       power_down;
  } cbo_conv_t;

  typedef struct packed {
    logic [4:0] upper;
    logic [2:0] sel;
  } cbo_ctl_byte_t;

endpackage

// File: tb.sv
// Self-checking testbench for the control byte and alarm block
`timescale 1ns/1ps
module tb;
  import cbo_pkg::*;
  localparam int TEMP_CYC = 20;
  localparam int ADC_CYC  = 8;
  logic       clk_sys;
  logic       rst_n;
  logic       sclk;
  logic       sdata_in;
  logic       rd_wr;
  logic       convert_start_n;
  logic [9:0] adc_result;
  logic [2:0] channel_select;
  logic       overtemp_alarm_n;
  cbo_conv_t  conv_status;
  int         num_errors;
  int         total_checks;
  int         cycles;
  logic [2:0] codes [5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h7};

  cbo_alarm_regs #(.TEMP_CONV_CYC(TEMP_CYC), .ADC_CONV_CYC(ADC_CYC)) i_cbo_alarm_regs (
    .clk_sys(clk_sys), .rst_n(rst_n), .sclk(sclk), .sdata_in(sdata_in), .rd_wr(rd_wr),
    .convert_start_n(convert_start_n), .adc_result(adc_result),
    .channel_select(channel_select), .overtemp_alarm_n(overtemp_alarm_n),
    .conv_status(conv_status));

  cbo_host_model i_cbo_host_model (
    .clk_sys(clk_sys), .sclk(sclk), .sdata_in(sdata_in), .rd_wr(rd_wr),
    .convert_start_n(convert_start_n));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Hang guard, far above the few thousand cycles the tests need
  always @(posedge clk_sys) begin
    cycles = cycles + 1;
    if (cycles == 30000) begin
      num_errors = num_errors + 1;
      print_verdict();
    end
  end

  task automatic check(input logic [11:0] seen, input logic [11:0] exp, input string what);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask

  // Result is held on the core side until the alarm has settled
  task automatic conv(input logic [9:0] adc, input logic hold, input int cyc, input logic bg);
    int n;
    n = 0;
    adc_result = adc;
    i_cbo_host_model.start();
    while (conv_status.busy !== 1'b1 && n < 20) begin
      @(negedge clk_sys);
      n++;
    end
    check(12'(conv_status.bandgap), 12'(bg), "band gap routing");
    check(12'(conv_status.hold), 12'h001, "track hold in hold");
    if (!hold) begin
      i_cbo_host_model.release_start();
    end
    n = 0;
    while (conv_status.busy === 1'b1 && n < 4000) begin
      @(negedge clk_sys);
      n++;
    end
    check(12'(n), 12'(cyc), "busy length");
    check(12'(conv_status.power_down), 12'(hold), "power down");
    check(12'({conv_status.busy, conv_status.hold, conv_status.bandgap}), 12'h000,
          "end status");
    i_cbo_host_model.release_start();
    i_cbo_host_model.idle(3);
  endtask

  initial begin
    rst_n        = 1'b0;
    adc_result   = 10'h000;
    num_errors   = 0;
    total_checks = 0;
    cycles       = 0;
    repeat (6) @(negedge clk_sys);
    rst_n = 1'b1;
    @(negedge clk_sys);
    check(12'(channel_select), 12'h000, "channel reset");
    check(12'(overtemp_alarm_n), 12'h001, "alarm reset");
    check(12'(conv_status), 12'h000, "status reset");
    $display("test reset done");
    conv({i_cbo_host_model.alarm_code(50), 2'b11}, 1'b0, TEMP_CYC, 1'b0);
    check(12'(overtemp_alarm_n), 12'h001, "equal is no alarm");
    conv({i_cbo_host_model.alarm_code(51), 2'b00}, 1'b0, TEMP_CYC, 1'b0);
    check(12'(overtemp_alarm_n), 12'h000, "above default");
    i_cbo_host_model.read_end();
    i_cbo_host_model.idle(3);
    check(12'(overtemp_alarm_n), 12'h001, "read end release");
    conv({i_cbo_host_model.alarm_code(51), 2'b00}, 1'b0, TEMP_CYC, 1'b0);
    $display("test alarm done");
    foreach (codes[i]) begin
      i_cbo_host_model.write_byte({5'h00, codes[i]});
      check(12'(channel_select), 12'(codes[i]), "channel write");
      conv(10'h000, 1'b0, ADC_CYC, codes[i] == 3'h7);
      check(12'(overtemp_alarm_n), 12'h000, "input channel keeps alarm");
    end
    $display("test channels done");
    i_cbo_host_model.write_byte(i_cbo_host_model.alarm_code(-95));
    check(12'(channel_select), 12'h007, "threshold write spares channel");
    i_cbo_host_model.write_byte(8'h00);
    check(12'(channel_select), 12'h000, "back to sensor");
    conv({8'h08, 2'b11}, 1'b0, TEMP_CYC, 1'b0);
    check(12'(overtemp_alarm_n), 12'h001, "lowest code release");
    conv({8'h09, 2'b00}, 1'b0, TEMP_CYC, 1'b0);
    check(12'(overtemp_alarm_n), 12'h000, "above lowest code");
    // Partial byte, then a whole byte clocked with read-write high
    i_cbo_host_model.write_bits(8'h00, 5, 1'b0);
    i_cbo_host_model.write_bits(8'h02, 8, 1'b1);
    i_cbo_host_model.idle(3);
    check(12'(channel_select), 12'h000, "read bits ignored");
    check(12'(overtemp_alarm_n), 12'h001, "second read end release");
    i_cbo_host_model.write_byte(8'h01);
    check(12'(channel_select), 12'h001, "partial byte dropped");
    i_cbo_host_model.write_byte(8'h00);
    check(12'(channel_select), 12'h000, "sensor again");
    $display("test refusal done");
    i_cbo_host_model.write_byte(i_cbo_host_model.alarm_code(152));
    conv(10'h3ff, 1'b1, TEMP_CYC, 1'b0);
    check(12'(overtemp_alarm_n), 12'h001, "top code unsigned");
    $display("test threshold done");
    i_cbo_host_model.write_byte(8'h04);
    check(12'(channel_select), 12'h004, "channel before reset");
    rst_n = 1'b0;
    i_cbo_host_model.idle(3);
    rst_n = 1'b1;
    @(negedge clk_sys);
    check(12'({channel_select, overtemp_alarm_n, conv_status}), 12'h010,
          "mid-run reset");
    conv({i_cbo_host_model.alarm_code(51), 2'b00}, 1'b0, TEMP_CYC, 1'b0);
    check(12'(overtemp_alarm_n), 12'h000, "default threshold after reset");
    $display("test mid-run reset done");
    print_verdict();
  end
endmodule // tb
